// [sram_regs.svh]
// timing and layout constants for the pipelined burst sram
`ifndef SRAM_REGS_SVH
`define SRAM_REGS_SVH
`define SRAM_ADDR_W 15
`define SRAM_DATA_W 36
`define SRAM_LANES 4
`define SRAM_LANE_W 9
`define SRAM_BURST_W 2
`define SRAM_CLK_NS 40
`endif

// [sram_pkg.sv]
// types shared by the pipelined burst sram
package sram_pkg;
    typedef enum logic [1:0] {
        CYC_IDLE = 2'b00,
        CYC_READ = 2'b01,
        CYC_WRITE = 2'b10
    } cyc_t;
endpackage

// [burst_counter.sv]
// two-bit burst counter with linear or interleaved order
`timescale 1ns/1ns
`include "sram_regs.svh"
module burst_counter #(
    parameter int W = `SRAM_BURST_W
) (
    // clock
    input wire logic ref_clk,
    input wire logic rst,
    // control
    input wire logic load,
    input wire logic [W-1:0] start,
    input wire logic step,
    input wire logic interleaved,
    // result
    output logic [W-1:0] low_addr
);
    logic [W-1:0] start_r, start_nxt;
    logic [W-1:0] cnt_r, cnt_nxt;

    always_comb begin
        start_nxt = start_r;
        cnt_nxt = cnt_r;
        if (load) begin
            start_nxt = start;
            cnt_nxt = '0;
        end else if (step) begin
            cnt_nxt = W'(cnt_r + 1'b1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            start_r <= '0;
            cnt_r <= '0;
        end else begin
            start_r <= start_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // interleaved order xors the beat count into the start
    assign low_addr = interleaved ? (start_r ^ cnt_r) : W'(start_r + cnt_r);
endmodule

// [pipelined_burst_sram.sv]
// pipelined burst sram, 32k x 36, with double-cycle deselect
// Operation
// - all synchronous inputs captured on the rising clock edge only
// - output enable acts without the clock; sleep passes two clocked stages first
// - array of 32K words of 36 bits, address selects one
// - address and selects load only when a strobe is active
// - address taken only with a strobe low and all selects active
// - two low address bits load into the burst counter
// - later burst addresses are made inside under advance control
// - counter steps when advance sampled low, holds otherwise
// - linear or interleaved burst order selectable
// - burst runs 3-1-1-1
// - first select low-active; high masks processor strobe
// - second select high-active, combined with the other two
// - address, data and write controls registered, write self-timed
// - write touches any of four lanes by low-active lane selects
// - lane selects act only with byte-write qualifier low
// - global write low writes all four lanes
// - drivers stay on one extra cycle after deselect
// - both strobes together: processor strobe only
// - read data comes from the address sampled two edges earlier
// - output enable masked in second data clock out of deselect
// - sleep high freezes activity and keeps the data
`timescale 1ns/1ns
`include "sram_regs.svh"
module pipelined_burst_sram #(
    parameter int AW = `SRAM_ADDR_W,
    parameter int DW = `SRAM_DATA_W,
    parameter int NL = `SRAM_LANES,
    parameter int LW = `SRAM_LANE_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // address and strobes (all low-active except chip_select_high)
    input wire logic [AW-1:0] addr,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic chip_select_primary_n,
    input wire logic chip_select_high,
    input wire logic chip_select_third_n,
    // write controls
    input wire logic [NL-1:0] byte_lane_write_sel_n,
    input wire logic byte_write_qualifier_n,
    input wire logic all_bytes_write_n,
    // mode and asynchronous controls
    input wire logic interleaved_mode,
    input wire logic out_enable_n,
    input wire logic sleep_request,
    // data pins, parity_lanes are bits 8, 17, 26, 35
    input wire logic [DW-1:0] data_in,
    output logic [DW-1:0] data_out,
    output logic data_oe_n
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // input registers: the clocked pins are captured here, nothing else reads them raw
    logic [AW-1:0] a_r;
    logic ps_r, cs_r, adv_r, ce1_r, ce2_r, ce3_r, bwq_r, gw_r;
    logic [NL-1:0] bw_r;
    logic [DW-1:0] din_r;
    logic sleep_s1_r, sleep_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            a_r <= '0;
            ps_r <= 1'b1;
            cs_r <= 1'b1;
            adv_r <= 1'b1;
            ce1_r <= 1'b1;
            ce2_r <= 1'b0;
            ce3_r <= 1'b1;
            bwq_r <= 1'b1;
            gw_r <= 1'b1;
            bw_r <= '1;
            din_r <= '0;
            sleep_s1_r <= 1'b0;
            sleep_r <= 1'b0;
        end else begin
            a_r <= addr;
            ps_r <= processor_addr_strobe_n;
            cs_r <= controller_addr_strobe_n;
            adv_r <= burst_advance_n;
            ce1_r <= chip_select_primary_n;
            ce2_r <= chip_select_high;
            ce3_r <= chip_select_third_n;
            bwq_r <= byte_write_qualifier_n;
            gw_r <= all_bytes_write_n;
            bw_r <= byte_lane_write_sel_n;
            din_r <= data_in;
            sleep_s1_r <= sleep_request;
            sleep_r <= sleep_s1_r;
        end
    end

    // decoded strobe and select terms of the sampled inputs
    logic sel_all, ps_go, cs_go, start, wr_any;
    logic [NL-1:0] lane_we;
    assign sel_all = !ce1_r && ce2_r && !ce3_r;
    assign ps_go = !ps_r && !ce1_r;
    assign cs_go = !cs_r && ps_r;
    assign start = ps_go || cs_go;

    // processor-strobe cycles are always reads; writes follow on later edges
    assign lane_we = !gw_r ? '1 : (!bwq_r ? ~bw_r : '0);
    assign wr_any = |lane_we;

    // cycle state
    sram_pkg::cyc_t cyc_r, cyc_nxt;
    logic [AW-1:0] base_r, base_nxt;
    logic load, step;
    logic [1:0] low_addr;

    always_comb begin
        cyc_nxt = cyc_r;
        base_nxt = base_r;
        load = 1'b0;
        step = 1'b0;
        if (!sleep_r) begin
            if (start) begin
                if (sel_all) begin
                    load = 1'b1;
                    base_nxt = a_r;
                    cyc_nxt = (cs_go && wr_any) ? sram_pkg::CYC_WRITE : sram_pkg::CYC_READ;
                end else begin
                    cyc_nxt = sram_pkg::CYC_IDLE;
                end
            end else if (cyc_r != sram_pkg::CYC_IDLE) begin
                step = !adv_r;
                cyc_nxt = wr_any ? sram_pkg::CYC_WRITE : sram_pkg::CYC_READ;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cyc_r <= sram_pkg::CYC_IDLE;
            base_r <= '0;
        end else begin
            cyc_r <= cyc_nxt;
            base_r <= base_nxt;
        end
    end

    burst_counter #(
        .W(2)
    ) u_burst (
        .ref_clk(ref_clk),
        .rst(rst),
        .load(load),
        .start(a_r[1:0]),
        .step(step),
        .interleaved(interleaved_mode),
        .low_addr(low_addr)
    );

    // effective address: upper bits fixed over the burst
    logic [AW-1:0] eff_addr;
    assign eff_addr = {base_r[AW-1:2], low_addr};

    // write happens two edges after capture with registered data
    logic [NL-1:0] wlane_r;
    logic [DW-1:0] wdata_r;
    logic [AW-1:0] waddr_r;
    logic wpend_r;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wlane_r <= '0;
            wdata_r <= '0;
            waddr_r <= '0;
            wpend_r <= 1'b0;
        end else begin
            // the strobe cycle itself writes, at the address it carries
            wpend_r <= !sleep_r && (cyc_nxt == sram_pkg::CYC_WRITE);
            wlane_r <= lane_we;
            wdata_r <= din_r;
            waddr_r <= load ? a_r : eff_addr;
        end
    end

    // self-timed array write, one lane per byte select
    for (genvar l = 0; l < NL; l++) begin : g_lane
        always_ff @(posedge ref_clk) begin
            if (wpend_r && wlane_r[l] && !sleep_r) begin
                mem[waddr_r][l*LW +: LW] <= wdata_r[l*LW +: LW];
            end
        end
    end

    // output pipeline: array read then output register
    logic rd_r, drv_r, first_r;
    logic [DW-1:0] dout_r;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_r <= 1'b0;
            drv_r <= 1'b0;
            first_r <= 1'b0;
            dout_r <= '0;
        end else begin
            rd_r <= (cyc_r == sram_pkg::CYC_READ) && !sleep_r;
            if (cyc_r == sram_pkg::CYC_READ) begin
                dout_r <= mem[eff_addr];
            end
            // extra enable stage keeps drivers on one cycle past deselect
            drv_r <= rd_r;
            first_r <= rd_r && !drv_r;
        end
    end
    assign data_out = dout_r;
    // output enable is combinational: no clock between pin and driver
    assign data_oe_n = !((rd_r || drv_r) && (!out_enable_n || first_r));

    // checks
    AST_STRB_LOAD: assert property (@(posedge ref_clk) disable iff (rst)
        (start && sel_all && !sleep_r) |=> (base_r == $past(a_r)))
        else $error("address not loaded on strobe");
    AST_CE1_MASK: assert property (@(posedge ref_clk) disable iff (rst)
        (ce1_r && cs_r) |-> !load)
        else $error("processor strobe acted with primary select high");
    AST_PRIO: assert property (@(posedge ref_clk) disable iff (rst)
        (!ps_r && !cs_r && !ce1_r && sel_all && !sleep_r) |=> cyc_r == sram_pkg::CYC_READ)
        else $error("controller strobe won over processor strobe");
    AST_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        (!load && !step) ##1 $stable(interleaved_mode) |-> $stable(low_addr))
        else $error("burst counter moved without advance");
    AST_WRAP: assert property (@(posedge ref_clk) disable iff (rst)
        (!load) |=> (eff_addr[AW-1:2] == $past(eff_addr[AW-1:2])))
        else $error("burst left its group");
    AST_GW: assert property (@(posedge ref_clk) disable iff (rst)
        !gw_r |-> (lane_we == '1))
        else $error("global write missed a lane");
    AST_DCD: assert property (@(posedge ref_clk) disable iff (rst)
        (rd_r && !out_enable_n ##1 !rd_r && !out_enable_n) |-> !data_oe_n)
        else $error("drivers turned off without extra cycle");
    AST_SLEEP: assert property (@(posedge ref_clk) disable iff (rst)
        sleep_r |-> (!load && !step))
        else $error("activity during sleep");
    COV_READ: cover property (@(posedge ref_clk) disable iff (rst) load ##1 rd_r);
    COV_BURST: cover property (@(posedge ref_clk) disable iff (rst) step [*3]);
    COV_WRITE: cover property (@(posedge ref_clk) disable iff (rst) wpend_r);
endmodule

// [bus_master.sv]
// bus master model driving the synchronous pins of the sram
`timescale 1ns/1ns
module bus_master (
    // clock
    input wire logic ref_clk,
    // pins toward the memory
    output logic [14:0] addr,
    output logic processor_addr_strobe_n,
    output logic controller_addr_strobe_n,
    output logic burst_advance_n,
    output logic chip_select_primary_n,
    output logic [3:0] byte_lane_write_sel_n,
    output logic byte_write_qualifier_n,
    output logic all_bytes_write_n,
    output logic [35:0] data_in
);
    // released bus flips so a stale value never passes for a good one
    task automatic idle();
        processor_addr_strobe_n = 1'b1;
        controller_addr_strobe_n = 1'b1;
        burst_advance_n = 1'b1;
        chip_select_primary_n = 1'b0;
        byte_lane_write_sel_n = 4'hf;
        byte_write_qualifier_n = 1'b1;
        all_bytes_write_n = 1'b1;
        addr = ~addr;
        data_in = ~data_in;
    endtask
    initial begin
        addr = 15'h0000;
        data_in = 36'h0_0000_0000;
        idle();
    end
    task automatic wr(input logic [14:0] a, input logic [35:0] d, input logic gw_n,
            input logic q_n, input logic [3:0] ln_n);
        addr = a;
        data_in = d;
        controller_addr_strobe_n = 1'b0;
        all_bytes_write_n = gw_n;
        byte_write_qualifier_n = q_n;
        byte_lane_write_sel_n = ln_n;
        @(posedge ref_clk);
        #1 idle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    // controller strobe with the primary select high deselects the memory
    task automatic desel();
        controller_addr_strobe_n = 1'b0;
        chip_select_primary_n = 1'b1;
        @(posedge ref_clk);
        #1 idle();
    endtask
    task automatic rd(input logic [14:0] a, input logic cs_n, input logic adv_n);
        addr = a;
        processor_addr_strobe_n = 1'b0;
        chip_select_primary_n = cs_n;
        @(posedge ref_clk);
        #1 idle();
        burst_advance_n = adv_n;
    endtask
endmodule

// [testbench.sv]
// self-checking bench for the pipelined burst sram
`timescale 1ns/1ns
module testbench;
    logic ref_clk, rst, interleaved_mode, data_oe_n, processor_addr_strobe_n;
    logic controller_addr_strobe_n, burst_advance_n, chip_select_primary_n;
    logic byte_write_qualifier_n, all_bytes_write_n;
    logic [3:0] byte_lane_write_sel_n;
    logic [14:0] addr;
    logic [35:0] data_in, data_out;
    int fail_count = 0;
    int comparisons = 0;
    localparam logic [14:0] BASE = 15'h0120;
    bus_master i_bm (.ref_clk, .addr, .processor_addr_strobe_n, .controller_addr_strobe_n,
        .burst_advance_n, .chip_select_primary_n, .byte_lane_write_sel_n,
        .byte_write_qualifier_n, .all_bytes_write_n, .data_in);
    // other selects and output enable tied to their active levels, sleep tied inactive
    pipelined_burst_sram i_dut (.ref_clk, .rst, .addr, .processor_addr_strobe_n,
        .controller_addr_strobe_n, .burst_advance_n, .chip_select_primary_n,
        .chip_select_high(1'b1), .chip_select_third_n(1'b0), .byte_lane_write_sel_n,
        .byte_write_qualifier_n, .all_bytes_write_n, .interleaved_mode,
        .out_enable_n(1'b0), .sleep_request(1'b0), .data_in, .data_out, .data_oe_n);
    function automatic logic [35:0] word(input int i);
        return 36'h5_a5a5_0000 + 36'(i);
    endfunction
    task automatic chk_data(input logic [35:0] got, input logic [35:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // returns just after the edge that shows the first word
    task automatic start_read(input logic [14:0] a, input logic cs_n, input logic adv_n);
        i_bm.rd(a, cs_n, adv_n);
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic sc_fill();
        for (int i = 0; i < 4; i++) begin
            i_bm.wr(BASE + 15'(i), word(i), 1'b0, 1'b1, 4'hf);
        end
    endtask
    task automatic sc_burst(input logic mode, input int s);
        int e;
        interleaved_mode = mode;
        start_read(BASE + 15'(s), 1'b0, 1'b0);
        for (int k = 0; k < 4; k++) begin
            e = mode ? (s ^ k) : ((s + k) & 3);
            chk_data(data_out, word(e));
            @(posedge ref_clk);
            #1;
        end
        i_bm.idle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task automatic sc_bytes();
        logic [35:0] nw;
        logic [35:0] old;
        nw = 36'h1_2345_6789;
        old = word(0);
        i_bm.wr(BASE, nw, 1'b1, 1'b0, 4'he);
        // lanes low but qualifier high: nothing may change
        i_bm.wr(BASE, 36'h0_0000_0000, 1'b1, 1'b1, 4'h0);
        start_read(BASE, 1'b0, 1'b1);
        chk_data(data_out, {old[35:9], nw[8:0]});
        @(posedge ref_clk);
        #1;
        chk_flag(data_oe_n, 1'b0);
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    // processor strobe with primary select high must not end the running read
    task automatic sc_ignored();
        start_read(BASE + 15'h0002, 1'b1, 1'b1);
        chk_flag(data_oe_n, 1'b0);
        i_bm.desel();
        @(posedge ref_clk);
        #1;
        chk_flag(data_oe_n, 1'b0);
        @(posedge ref_clk);
        #1;
        chk_flag(data_oe_n, 1'b0);
        @(posedge ref_clk);
        #1;
        chk_flag(data_oe_n, 1'b1);
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        rst = 1'b1;
        interleaved_mode = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 rst = 1'b0;
        sc_fill();
        sc_burst(1'b0, 1);
        sc_burst(1'b1, 1);
        sc_burst(1'b0, 3);
        sc_bytes();
        sc_ignored();
        print_verdict();
    end
    // whole run needs under 150 cycles
    initial begin
        #80000;
        fail_count++;
        print_verdict();
    end
endmodule
